// >>> verilog/shsc_top.sv
// Standby controller for subsystem clock operation with HALT mode.
// Assumes an APB master on ref_clk and CPU status inputs synchronous to it.
//
// Summary of operation
// RULE1: Software never clears main-stop and clock-select bits in one write.
// RULE2: Settle wait follows a non-reset STOP release only on main clock.
// RULE3: No settle wait on return from subsystem clock; software times it.
// RULE4: Writing 45H in low power state enters HALT.
// RULE5: HALT gates the CPU clock; main oscillator stays off, subclock runs.
// RULE6: Port output latches hold their pre-HALT values during HALT.
// RULE7: 16-bit timer runs in HALT only via subclocked watch timer output.
// RULE8: 8-bit timers run in HALT only from their external inputs.
// RULE9: Watch timer runs in HALT only on the subsystem clock.
// RULE10: Real-time port runs in HALT on external trigger or external timers 1, 2.
// RULE11: Serial runs in HALT only with external clock; I2C mode stops.
// RULE12: Address and muxed address/data lines hold pre-HALT levels in HALT.
// RULE13: An enabled NMI edge ends HALT and restarts the CPU clock.
// RULE14: After NMI release, branch to NMI service if acceptable.
// RULE15: HALT set inside NMI service resumes; pending NMI taken at return.
// RULE16: Unmasked interrupt ends HALT; branch if enabled, else resume.
// RULE17: Reset releases HALT with a normal reset.
// RULE18: Software writes 40H, confirms, then 44H to enter low power.
// RULE19: Software writes 40H, waits settling, then 00H to return.
// RULE20: Clock gate reopens on next subclock tick; detection uses free clock.
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module shsc_top
  import shsc_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // CPU and interrupt status.
  input  wire logic        nmi_pin,
  input  wire logic        irq_req,
  input  wire logic        ie_flag,
  input  wire logic        nmi_in_service,
  input  wire logic        return_from_interrupt_instr_pulse,
  input  wire logic        stop_release,
  // Values the CPU drives while running.
  input  wire logic [7:0]  port_latch_in,
  input  wire logic [7:0]  muxed_addr_data_in,
  input  wire logic [19:0] address_in,
  // Clock control.
  output logic             cpu_clk_en,
  output logic             main_osc_en,
  output logic             sys_clk_sub,
  output logic             osc_settling,
  // Wake results.
  output logic             nmi_branch,
  output logic             irq_branch,
  output logic             resume_next,
  // Pins held during HALT.
  output logic [7:0]       port_out,
  output logic [7:0]       muxed_addr_data_lines,
  output logic [19:0]      address_lines,
  // Peripheral run enables.
  output logic             timer16_run,
  output logic [5:0]       timer8_run,
  output logic             watch_run,
  output logic             rtp_run,
  output logic             serial_run,
  output logic             i2c_run
);
  shsc_wake_if wk ();

  shsc_state_t       state_reg;
  logic [7:0]        standby_control_reg;
  logic [2:0]        osc_settle_time_reg;
  logic              rising_edge_enable_reg;
  logic              falling_edge_enable_reg;
  logic [CFG_W-1:0]  cfg_reg;
  logic              wake_nmi_reg;
  logic              nmi_deferred_reg;
  logic              bad_switch_reg;
  logic [SETTLE_W-1:0] settle_cnt_reg;
  logic [10:0]       wake_cnt_reg;
  logic              acc;
  logic              wr_en;
  logic              low_power;
  logic              halt_entry;
  logic              wake_now;
  logic              halted;
  logic [31:0]       rd_next;
  logic              hit;

  shsc_wake u_wake (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .nmi_pin (nmi_pin),
    .wk      (wk)
  );

  assign wk.nmi_rise_en = rising_edge_enable_reg;
  assign wk.nmi_fall_en = falling_edge_enable_reg;

  assign acc        = psel && penable && !pready;
  assign wr_en      = psel && penable && pready && pwrite;
  assign low_power  = standby_control_reg[MAIN_STOP_BIT] && standby_control_reg[CLK_SEL_BIT];
  assign halt_entry = wr_en && (paddr == STBY_CTRL_OFS) && (pwdata[7:0] == HALT_CODE) && low_power;
  assign halted     = (state_reg != SHSC_RUN);
  assign wake_now   = (state_reg == SHSC_HALT) && (wk.nmi_edge || irq_req);

  // Read mux.
  always_comb
  begin
    rd_next = 32'h0000_0000;
    hit     = 1'b1;
    case (paddr)
      STBY_CTRL_OFS:  rd_next[7:0] = standby_control_reg;
      SETTLE_OFS:     rd_next[2:0] = osc_settle_time_reg;
      RISE_EN_OFS:    rd_next[0] = rising_edge_enable_reg;
      FALL_EN_OFS:    rd_next[0] = falling_edge_enable_reg;
      PERIPH_CFG_OFS: rd_next[CFG_W-1:0] = cfg_reg;
      STATUS_OFS:     rd_next[4:0] = {bad_switch_reg, nmi_deferred_reg, osc_settling, halted, low_power};
      default:        hit = 1'b0;
    endcase
  end

  // APB answer one cycle into the access phase.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= acc;
      prdata  <= (acc && !pwrite) ? rd_next : 32'h0000_0000;
      pslverr <= acc && !hit;
    end
  end

  // Configuration registers.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      osc_settle_time_reg     <= SETTLE_RESET;
      rising_edge_enable_reg  <= 1'b0;
      falling_edge_enable_reg <= 1'b0;
      cfg_reg                 <= CFG_RESET;
    end
    else if (wr_en)
    begin
      case (paddr)
        SETTLE_OFS:     osc_settle_time_reg <= pwdata[2:0];
        RISE_EN_OFS:    rising_edge_enable_reg <= pwdata[0];
        FALL_EN_OFS:    falling_edge_enable_reg <= pwdata[0];
        PERIPH_CFG_OFS: cfg_reg <= pwdata[CFG_W-1:0];
        default:        ;
      endcase
    end
  end

  // Standby control and the illegal simultaneous clear flag.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      standby_control_reg <= STBY_RESET; // RULE17
      bad_switch_reg      <= 1'b0;
    end
    else
    begin
      if (wr_en && (paddr == STBY_CTRL_OFS))
      begin
        standby_control_reg <= pwdata[7:0];
        standby_control_reg[HALT_BIT] <= halt_entry; // RULE4
        if (low_power && !pwdata[MAIN_STOP_BIT] && !pwdata[CLK_SEL_BIT])
        begin
          bad_switch_reg <= 1'b1; // RULE1
        end
      end
      else if (wr_en && (paddr == STATUS_OFS))
      begin
        bad_switch_reg <= 1'b0;
      end
      if (state_reg == SHSC_WAKE && wk.sub_tick)
      begin
        standby_control_reg[HALT_BIT] <= 1'b0;
      end
    end
  end

  // HALT state machine on the free clock.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_reg    <= SHSC_RUN; // RULE17
      wake_nmi_reg <= 1'b0;
      cpu_clk_en   <= 1'b1;
    end
    else
    begin
      case (state_reg)
        SHSC_RUN:
        begin
          if (halt_entry)
          begin
            state_reg  <= SHSC_HALT; // RULE4
            cpu_clk_en <= 1'b0; // RULE5
          end
        end
        SHSC_HALT:
        begin
          if (wake_now)
          begin
            state_reg    <= SHSC_WAKE; // RULE13 RULE16 RULE20
            wake_nmi_reg <= wk.nmi_edge;
          end
        end
        SHSC_WAKE:
        begin
          if (wk.sub_tick)
          begin
            state_reg  <= SHSC_RUN;
            cpu_clk_en <= 1'b1; // RULE20
          end
        end
        default: state_reg <= SHSC_RUN;
      endcase
    end
  end

  // Wake outcome pulses and the deferred NMI.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      nmi_branch       <= 1'b0;
      irq_branch       <= 1'b0;
      resume_next      <= 1'b0;
      nmi_deferred_reg <= 1'b0;
    end
    else
    begin
      nmi_branch  <= 1'b0;
      irq_branch  <= 1'b0;
      resume_next <= 1'b0;
      if (state_reg == SHSC_WAKE && wk.sub_tick)
      begin
        if (wake_nmi_reg && !nmi_in_service)
        begin
          nmi_branch <= 1'b1; // RULE14
        end
        else if (wake_nmi_reg)
        begin
          resume_next      <= 1'b1; // RULE15
          nmi_deferred_reg <= 1'b1;
        end
        else if (ie_flag)
        begin
          irq_branch <= 1'b1; // RULE16
        end
        else
        begin
          resume_next <= 1'b1; // RULE16
        end
      end
      else if (nmi_deferred_reg && return_from_interrupt_instr_pulse)
      begin
        nmi_branch       <= 1'b1; // RULE15
        nmi_deferred_reg <= 1'b0;
      end
    end
  end

  // Oscillator control and settle counter.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      main_osc_en    <= 1'b1;
      sys_clk_sub    <= 1'b0;
      osc_settling   <= 1'b0;
      settle_cnt_reg <= '0;
    end
    else
    begin
      main_osc_en <= !standby_control_reg[MAIN_STOP_BIT]; // RULE5
      sys_clk_sub <= standby_control_reg[CLK_SEL_BIT];
      if (stop_release && !standby_control_reg[CLK_SEL_BIT]) // RULE3
      begin
        osc_settling   <= 1'b1; // RULE2
        settle_cnt_reg <= SETTLE_W'((32'(osc_settle_time_reg) + 32'd1) * SETTLE_UNIT);
      end
      else if (osc_settling)
      begin
        settle_cnt_reg <= settle_cnt_reg - SETTLE_W'(1);
        osc_settling   <= (settle_cnt_reg != SETTLE_W'(1));
      end
    end
  end

  // Pin values follow the CPU while running and hold while halted.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      port_out              <= 8'h00;
      muxed_addr_data_lines <= 8'h00;
      address_lines         <= 20'h00000;
    end
    else if (!halted && !halt_entry)
    begin
      port_out              <= port_latch_in; // RULE6
      muxed_addr_data_lines <= muxed_addr_data_in; // RULE12
      address_lines         <= address_in; // RULE12
    end
  end

  // Peripheral run enables.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_T8; gi++)
    begin : g_t8
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
        begin
          timer8_run[gi] <= 1'b1;
        end
        else
        begin
          timer8_run[gi] <= !halted || cfg_reg[CFG_T8_LSB + gi]; // RULE8
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      timer16_run <= 1'b1;
      watch_run   <= 1'b1;
      rtp_run     <= 1'b1;
      serial_run  <= 1'b1;
      i2c_run     <= 1'b1;
    end
    else
    begin
      timer16_run <= !halted || (cfg_reg[CFG_T16_WATCH] && cfg_reg[CFG_WATCH_SUB]); // RULE7
      watch_run   <= !halted || cfg_reg[CFG_WATCH_SUB]; // RULE9
      rtp_run     <= !halted || cfg_reg[CFG_RTP_EXT] ||
                     (cfg_reg[CFG_T8_LSB] && cfg_reg[CFG_T8_LSB + 1]); // RULE10
      serial_run  <= !halted || (cfg_reg[CFG_SER_EXT] && !cfg_reg[CFG_I2C_MODE]); // RULE11
      i2c_run     <= !halted; // RULE11
    end
  end

  // Counts the cycles spent waiting for the reopening tick.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || state_reg != SHSC_WAKE)
    begin
      wake_cnt_reg <= 11'h000;
    end
    else
    begin
      wake_cnt_reg <= wake_cnt_reg + 11'h001;
    end
  end

  // Checks.
  property p_halt_entry;
    @(posedge ref_clk) disable iff (!rst_n)
      halt_entry |=> (state_reg == SHSC_HALT) && !cpu_clk_en;
  endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("halt not entered"); // RULE4

  property p_gate_closed;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == SHSC_HALT) |-> !cpu_clk_en && !main_osc_en;
  endproperty
  a_gate_closed: assert property (p_gate_closed) else $error("cpu clock open in halt"); // RULE5

  property p_port_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      halted ##1 halted |-> $stable(port_out);
  endproperty
  a_port_hold: assert property (p_port_hold) else $error("port latch moved in halt"); // RULE6

  property p_bus_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      halted ##1 halted |-> $stable(address_lines) && $stable(muxed_addr_data_lines);
  endproperty
  a_bus_hold: assert property (p_bus_hold) else $error("bus lines moved in halt"); // RULE12

  property p_nmi_wake;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == SHSC_HALT) && wk.nmi_edge |=> (state_reg == SHSC_WAKE) && !cpu_clk_en;
  endproperty
  a_nmi_wake: assert property (p_nmi_wake) else $error("nmi did not release halt"); // RULE13

  property p_wake_bound;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == SHSC_WAKE) |-> (wake_cnt_reg <= SUB_DIV_LAST);
  endproperty
  a_wake_bound: assert property (p_wake_bound) else $error("gate not reopened within a subclock period"); // RULE20

  property p_wake_outcome;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == SHSC_WAKE) && wk.sub_tick |=> nmi_branch || irq_branch || resume_next;
  endproperty
  a_wake_outcome: assert property (p_wake_outcome) else $error("no outcome after release"); // RULE16

  property p_gate_reopen;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == SHSC_WAKE) && wk.sub_tick |=> cpu_clk_en && !halted;
  endproperty
  a_gate_reopen: assert property (p_gate_reopen) else $error("gate not reopened on tick"); // RULE20

  property p_nmi_branch;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == SHSC_WAKE) && wk.sub_tick && wake_nmi_reg && !nmi_in_service |=> nmi_branch;
  endproperty
  a_nmi_branch: assert property (p_nmi_branch) else $error("no nmi branch"); // RULE14

  property p_nmi_deferred;
    @(posedge ref_clk) disable iff (!rst_n)
      nmi_deferred_reg && return_from_interrupt_instr_pulse |=> nmi_branch && !nmi_deferred_reg;
  endproperty
  a_nmi_deferred: assert property (p_nmi_deferred) else $error("deferred nmi lost"); // RULE15

  property p_irq_wake;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == SHSC_HALT) && irq_req |=> (state_reg == SHSC_WAKE) && !cpu_clk_en;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("irq did not release halt"); // RULE16

  property p_settle;
    @(posedge ref_clk) disable iff (!rst_n)
      stop_release && !standby_control_reg[CLK_SEL_BIT] |=> osc_settling [*8];
  endproperty
  a_settle: assert property (p_settle) else $error("settle wait missing"); // RULE2

  property p_no_settle_on_return;
    @(posedge ref_clk) disable iff (!rst_n)
      !osc_settling && !stop_release |=> !osc_settling;
  endproperty
  a_no_settle_on_return: assert property (p_no_settle_on_return) else $error("settle without stop release"); // RULE3

  property p_t8_stop;
    @(posedge ref_clk) disable iff (!rst_n)
      halted && $stable(cfg_reg) ##1 halted |-> (timer8_run == cfg_reg[CFG_T8_LSB +: NUM_T8]);
  endproperty
  a_t8_stop: assert property (p_t8_stop) else $error("8-bit timer gating wrong"); // RULE8

  c_halt_nmi: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(cpu_clk_en) && nmi_branch);
  c_halt_irq: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(cpu_clk_en) && irq_branch);
  c_deferred: cover property (@(posedge ref_clk) disable iff (!rst_n) resume_next && nmi_deferred_reg);
endmodule
`default_nettype wire

// >>> verilog/shsc_pkg.sv
// Package for the subclock HALT standby control block.
// Assumes a 40 MHz reference clock and a 32.768 kHz subsystem clock rate.
package shsc_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] STBY_CTRL_OFS   = 8'h00;
  localparam logic [7:0] SETTLE_OFS      = 8'h04;
  localparam logic [7:0] RISE_EN_OFS     = 8'h08;
  localparam logic [7:0] FALL_EN_OFS     = 8'h0c;
  localparam logic [7:0] PERIPH_CFG_OFS  = 8'h10;
  localparam logic [7:0] STATUS_OFS      = 8'h14;
  // Standby control fields and codes.
  localparam int         HALT_BIT        = 0;
  localparam int         MAIN_STOP_BIT   = 2;
  localparam int         CLK_SEL_BIT     = 6;
  localparam logic [7:0] STBY_RESET      = 8'h00;
  localparam logic [7:0] HALT_CODE       = 8'h45;
  // Peripheral configuration fields.
  localparam int         CFG_T16_WATCH   = 0;
  localparam int         CFG_WATCH_SUB   = 1;
  localparam int         CFG_T8_LSB      = 2;
  localparam int         NUM_T8          = 6;
  localparam int         CFG_RTP_EXT     = 8;
  localparam int         CFG_SER_EXT     = 9;
  localparam int         CFG_I2C_MODE    = 10;
  localparam int         CFG_W           = 11;
  localparam logic [10:0] CFG_RESET      = 11'h000;
  localparam logic [2:0] SETTLE_RESET    = 3'h0;
  // Timing.
  localparam int         CLK_HZ          = 40000000;
  localparam int         SUB_CLK_HZ      = 32768;
  localparam int         SUB_DIV         = CLK_HZ / SUB_CLK_HZ;
  localparam logic [10:0] SUB_DIV_LAST   = 11'(SUB_DIV - 1);
  localparam int         SETTLE_UNIT     = 256;
  localparam int         SETTLE_W        = 12;
  typedef enum logic [1:0] {SHSC_RUN, SHSC_HALT, SHSC_WAKE} shsc_state_t;
endpackage

// >>> verilog/shsc_wake_if.sv
// Interface between the standby controller and its wake detector.
// Assumes all signals are synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface shsc_wake_if;
  logic nmi_rise_en;
  logic nmi_fall_en;
  logic nmi_edge;
  logic sub_tick;
  modport ctrl (output nmi_rise_en, output nmi_fall_en, input nmi_edge, input sub_tick);
  modport det  (input nmi_rise_en, input nmi_fall_en, output nmi_edge, output sub_tick);
endinterface
`default_nettype wire

// >>> verilog/shsc_wake.sv
// NMI edge detector and subsystem clock tick divider.
// Assumes the NMI pin is synchronous to ref_clk; runs on the ungated clock.
`timescale 1ns/1ps
`default_nettype none
module shsc_wake
  import shsc_pkg::*;
(
  // Clock and reset.
  input  wire logic   ref_clk,
  input  wire logic   rst_n,
  // Pin.
  input  wire logic   nmi_pin,
  // Controller side.
  shsc_wake_if.det    wk
);
  logic        nmi_prev_reg;
  logic [10:0] div_reg;

  // Edge detection runs on the free clock so a halted CPU never hides it.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      nmi_prev_reg <= nmi_pin;
      wk.nmi_edge  <= 1'b0;
    end
    else
    begin
      nmi_prev_reg <= nmi_pin;
      wk.nmi_edge  <= (wk.nmi_rise_en && nmi_pin && !nmi_prev_reg) ||
                      (wk.nmi_fall_en && !nmi_pin && nmi_prev_reg);
    end
  end

  // One-cycle tick at the subsystem clock rate.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      div_reg     <= 11'h000;
      wk.sub_tick <= 1'b0;
    end
    else
    begin
      div_reg     <= (div_reg == SUB_DIV_LAST) ? 11'h000 : div_reg + 11'h001;
      wk.sub_tick <= (div_reg == SUB_DIV_LAST);
    end
  end
endmodule
`default_nettype wire

// >>> bench/subclock_halt_standby_control_test.sv
// Self-checking testbench for the subclock HALT standby controller.
// Assumes shsc_pkg, the wake interface and shsc_top are compiled first; the bench drives every port.
`timescale 1ns/1ps
`default_nettype none
module subclock_halt_standby_control_test;
  import shsc_pkg::*;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        nmi_pin, irq_req, ie_flag, nmi_in_service, return_from_interrupt_instr_pulse, stop_release;
  logic [7:0]  port_latch_in, muxed_addr_data_in, port_out, muxed_addr_data_lines;
  logic [19:0] address_in, address_lines;
  logic        cpu_clk_en, main_osc_en, sys_clk_sub, osc_settling, nmi_branch, irq_branch, resume_next;
  logic        timer16_run, watch_run, rtp_run, serial_run, i2c_run;
  logic [5:0]  timer8_run;
  logic [32:0] apb_q[$];
  logic [3:0]  wake_q[$];
  logic [32:0] ex_apb;
  logic [10:0] cfg;
  logic [35:0] hold;
  logic [3:0]  code [5] = '{4'hc, 4'hc, 4'ha, 4'h9, 4'h9};
  int          miscompares, tests_run, s, n;

  shsc_top dut_u (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .nmi_pin, .irq_req, .ie_flag, .nmi_in_service, .return_from_interrupt_instr_pulse, .stop_release, .port_latch_in,
    .muxed_addr_data_in, .address_in, .cpu_clk_en, .main_osc_en, .sys_clk_sub, .osc_settling, .nmi_branch,
    .irq_branch, .resume_next, .port_out, .muxed_addr_data_lines, .address_lines, .timer16_run, .timer8_run,
    .watch_run, .rtp_run, .serial_run, .i2c_run);

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("Checks run %0d, miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
                     input logic err);
    int k;
    apb_q.push_back({err, e});
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (pready !== 1'b1);
    chk(k, 2);
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wait_wake;
    for (int k = 0; k < 3000 && wake_q.size() != 0; k++)
      @(posedge ref_clk);
    chk(wake_q.size(), 0);
    wake_q.delete();
  endtask

  task automatic pulse_stop;
    @(posedge ref_clk);
    stop_release <= 1'b1;
    @(posedge ref_clk);
    stop_release <= 1'b0;
    #1;
    n = 0;
    for (int k = 0; k < 2200; k++)
    begin
      if (osc_settling === 1'b1) n++;
      @(posedge ref_clk);
      #1;
    end
  endtask

  task automatic set_pins;
    port_latch_in <= 8'($urandom); muxed_addr_data_in <= 8'($urandom); address_in <= 20'($urandom);
  endtask

  task automatic halt_enter;
    cfg = 11'($urandom);
    apb(1'b1, PERIPH_CFG_OFS, {21'h0, cfg}, 32'h0, 1'b0);
    set_pins();
    @(posedge ref_clk);
    hold = {port_latch_in, muxed_addr_data_in, address_in};
    apb(1'b1, STBY_CTRL_OFS, 32'h45, 32'h0, 1'b0);
    repeat (3) @(posedge ref_clk);
    #1;
    chk({cpu_clk_en, main_osc_en, sys_clk_sub}, 3'b001);
    chk(timer16_run, cfg[0] & cfg[1]);
    chk(timer8_run, cfg[7:2]);
    chk(watch_run, cfg[1]);
    chk(rtp_run, cfg[8] | (cfg[2] & cfg[3]));
    chk({serial_run, i2c_run}, {cfg[9] & ~cfg[10], 1'b0});
    repeat (8)
    begin
      @(posedge ref_clk);
      set_pins();
      #1;
      chk(port_out, hold[35:28]);
      chk({muxed_addr_data_lines, address_lines}, hold[27:0]);
    end
  endtask

  always @(posedge ref_clk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      ex_apb = (apb_q.size() != 0) ? apb_q.pop_front() : 33'h1ffffffff;
      chk(pslverr, ex_apb[32]);
      if (pwrite === 1'b0) chk(prdata, ex_apb[31:0]);
    end
    if ((nmi_branch | irq_branch | resume_next) === 1'b1)
      chk({cpu_clk_en, nmi_branch, irq_branch, resume_next}, wake_q.size() ? wake_q.pop_front() : 4'h0);
  end

  initial
  begin
    repeat (50000) @(posedge ref_clk);
    miscompares++;
    results();
  end

  initial
  begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    nmi_pin = 1'b0; irq_req = 1'b0; ie_flag = 1'b0; nmi_in_service = 1'b0; return_from_interrupt_instr_pulse = 1'b0;
    stop_release = 1'b0; port_latch_in = 8'h00; muxed_addr_data_in = 8'h00; address_in = 20'h0;
    s = $urandom(44);
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk({cpu_clk_en, main_osc_en, sys_clk_sub, osc_settling}, 4'b1100);
    chk({timer16_run, timer8_run, watch_run, rtp_run, serial_run, i2c_run}, 11'h7ff);
    for (int a = 0; a < 6; a++)
      apb(1'b0, 8'(a * 4), 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h18, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h1c, 32'hffffffff, 32'h0, 1'b1);
    s = $urandom_range(7, 0);
    apb(1'b1, SETTLE_OFS, 32'(s), 32'h0, 1'b0);
    apb(1'b0, SETTLE_OFS, 32'h0, 32'(s), 1'b0);
    pulse_stop();
    chk(n, (s + 1) * SETTLE_UNIT);
    apb(1'b1, STBY_CTRL_OFS, 32'h40, 32'h0, 1'b0);
    apb(1'b1, STBY_CTRL_OFS, 32'h45, 32'h0, 1'b0);
    apb(1'b0, STBY_CTRL_OFS, 32'h0, 32'h44, 1'b0);
    apb(1'b0, STATUS_OFS, 32'h0, 32'h01, 1'b0);
    pulse_stop();
    chk(n, 0);
    chk(cpu_clk_en, 1'b1);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, RISE_EN_OFS, 32'(i == 0 || i == 4), 32'h0, 1'b0);
      apb(1'b1, FALL_EN_OFS, 32'(i == 1), 32'h0, 1'b0);
      nmi_in_service <= (i == 4);
      ie_flag <= (i == 2);
      halt_enter();
      wake_q.push_back(code[i]);
      @(posedge ref_clk);
      nmi_pin <= ~nmi_pin;
      if (i == 2 || i == 3)
      begin
        repeat (2500) @(posedge ref_clk);
        #1;
        chk(cpu_clk_en, 1'b0);
        @(posedge ref_clk);
        irq_req <= 1'b1;
      end
      wait_wake();
      irq_req <= 1'b0;
      if (i == 4)
      begin
        apb(1'b0, STATUS_OFS, 32'h0, 32'h09, 1'b0);
        wake_q.push_back(4'hc);
        @(posedge ref_clk);
        return_from_interrupt_instr_pulse <= 1'b1;
        @(posedge ref_clk);
        return_from_interrupt_instr_pulse <= 1'b0;
        nmi_in_service <= 1'b0;
        wait_wake();
      end
      set_pins();
      repeat (3) @(posedge ref_clk);
      #1;
      chk(port_out, port_latch_in);
      chk({cpu_clk_en, timer16_run, timer8_run, watch_run, rtp_run, serial_run, i2c_run}, 12'hfff);
    end
    apb(1'b1, STBY_CTRL_OFS, 32'h40, 32'h0, 1'b0);
    pulse_stop();
    chk(n, 0);
    chk(main_osc_en, 1'b1);
    apb(1'b1, STBY_CTRL_OFS, 32'h00, 32'h0, 1'b0);
    apb(1'b1, STBY_CTRL_OFS, 32'h40, 32'h0, 1'b0);
    apb(1'b1, STBY_CTRL_OFS, 32'h44, 32'h0, 1'b0);
    apb(1'b1, STBY_CTRL_OFS, 32'h00, 32'h0, 1'b0);
    apb(1'b0, STATUS_OFS, 32'h0, 32'h10, 1'b0);
    apb(1'b1, STATUS_OFS, 32'h10, 32'h0, 1'b0);
    apb(1'b0, STATUS_OFS, 32'h0, 32'h00, 1'b0);
    apb(1'b1, STBY_CTRL_OFS, 32'h40, 32'h0, 1'b0);
    apb(1'b1, STBY_CTRL_OFS, 32'h44, 32'h0, 1'b0);
    halt_enter();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk({cpu_clk_en, main_osc_en, sys_clk_sub}, 3'b110);
    apb(1'b0, STBY_CTRL_OFS, 32'h0, 32'h0, 1'b0);
    repeat (4) @(posedge ref_clk);
    results();
  end
endmodule
`default_nettype wire
